/* File: bench/ssst_master_model.sv */
// External synchronous master: makes the shift clock, captures data.
// Assumes data moves after a falling edge and is read on the rise.
`timescale 1ns/1ps
module ssst_master_model (
    input  wire logic        run,      // Clock frames while high
    input  wire logic        clr,      // Clears the capture
    input  wire logic        data_out, // Serial data in
    input  wire logic        data_oe,  // Device drives data
    output logic             clk_pin,  // Shift clock, idles high
    output logic      [31:0] cap,      // Bits enter at the top
    output int               ncap      // Bits captured
);
    // Clock stands still high between frames
    initial begin
        clk_pin = 1'b1;
        forever begin
            wait (run);
            #62.5;
            // A frame that was stopped meanwhile gets no further pulse
            if (run) begin
                clk_pin = 1'b0;
                #62.5 clk_pin = 1'b1;
            end
        end
    end
    // Sample only while the device drives the line
    always @(posedge clk_pin or posedge clr) begin
        if (clr) begin
            cap <= 32'h0;
            ncap <= 0;
        end else if (data_oe) begin
            cap <= {data_out, cap[31:1]};
            ncap <= ncap + 1;
        end
    end
endmodule

/* File: bench/ssst_props.sv */
// Port checker for the slave transmitter top.
// Assumes it is bound to ssst_top and sees only its ports.
`timescale 1ns/1ps
module ssst_props (
    input wire logic        pclk,        // Clock
    input wire logic        presetn,     // Reset, active low
    input wire logic        psel,        // APB select
    input wire logic        penable,     // APB enable
    input wire logic        pwrite,      // APB direction
    input wire logic [31:0] prdata,      // APB read data
    input wire logic        pready,      // APB ready
    input wire logic        pslverr,     // APB error
    input wire logic        clk_pin_in,  // Shift clock
    input wire logic        clk_pin_out, // Clock drive
    input wire logic        clk_pin_oe,  // Clock enable
    input wire logic        data_out,    // Serial data
    input wire logic        data_oe      // Data enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus setup and shift clock rise
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rise;
        $rose(clk_pin_in) && data_oe;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_clk_not_driven: assert property (!clk_pin_oe && !clk_pin_out)
        else $error("slave drives shift clock");
    a_idle_line_high: assert property (!data_oe && !$past(data_oe) |-> data_out)
        else $error("idle data line not high");
    // Data may only move while the clock is low, so the master samples a settled bit
    a_stable_after_rise: assert property (s_rise |-> $stable(data_out) [*5])
        else $error("data moved after clock rise");
    a_change_when_low: assert property (
        data_oe && $past(data_oe) && $changed(data_out) |-> !clk_pin_in)
        else $error("data moved while clock high");
endmodule

/* File: bench/sync_slave_serial_transmit_tb.sv */
// Testbench for the slave transmitter: APB master, shift clock master.
// Assumes the design package and the external master model.
`timescale 1ns/1ps
module sync_slave_serial_transmit_tb;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} ssst_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, w;
    logic        clk_pin, run, clr, data_out, data_oe, irq, wake;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, cap;
    int          failures, cmp_count, ncap, i;
    // Reset values and an unmapped address
    ssst_row_t rows[6] = '{'{ssst_pkg::OFF_TX_CTRL, 32'h82, 1'b0},
        '{ssst_pkg::OFF_FLAGS3, 32'h10, 1'b0}, '{ssst_pkg::OFF_INT_CTRL, 32'h0, 1'b0},
        '{ssst_pkg::OFF_ENABLES3, 32'h0, 1'b0}, '{ssst_pkg::OFF_RX_CTRL, 32'h0, 1'b0},
        '{8'h28, 32'h0, 1'b1}};
    ssst_top i_ssst_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_pin_in(clk_pin), .clk_pin_out(), .clk_pin_oe(),
        .data_out(data_out), .data_oe(data_oe), .irq(irq), .wake(wake));
    ssst_master_model i_ssst_master_model (.run(run), .clr(clr), .data_out(data_out),
        .data_oe(data_oe), .clk_pin(clk_pin), .cap(cap), .ncap(ncap));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    // One APB transfer; waits for ready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            failures++;
            end_sim();
        end
    endtask
    // Lets the master clock until n bits are in
    task automatic bits(input int n);
        int k;
        run <= 1'b1;
        for (k = 0; k < 20000 && ncap < n; k++) @(negedge pclk);
        if (k == 20000) begin
            failures++;
            end_sim();
        end
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, run, presetn} = '0;
        {clr, failures, cmp_count} = '0;
        clr = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        clr <= 1'b0;
        foreach (rows[r]) begin
            apb(1'b0, rows[r].a, 32'h0);
            chk("read data", rd, rows[r].d);
            chk("error", {31'h0, err}, {31'h0, rows[r].e});
        end
        $display("reset values test done");
        // Slave setup, two words queued, then sleep
        apb(1'b1, ssst_pkg::OFF_RX_CTRL, 32'h80);
        apb(1'b1, ssst_pkg::OFF_TX_CTRL, 32'h30);
        apb(1'b1, ssst_pkg::OFF_ENABLES3, 32'h10);
        apb(1'b1, ssst_pkg::OFF_INT_CTRL, 32'hC0);
        apb(1'b1, ssst_pkg::OFF_TX_HOLD, 32'hA5);
        apb(1'b1, ssst_pkg::OFF_TX_HOLD, 32'h3C);
        apb(1'b1, ssst_pkg::OFF_SLEEP, 32'h1);
        apb(1'b0, ssst_pkg::OFF_FLAGS3, 32'h0);
        chk("flag held", rd[4], 1'b0);
        bits(7);
        chk("irq asleep", irq, 1'b0);
        w = 1'b0;
        for (i = 0; i < 400 && !w; i++) begin
            @(negedge pclk);
            w = wake;
        end
        chk("wake", w, 1'b1);
        chk("irq", irq, 1'b1);
        bits(16);
        run <= 1'b0;
        chk("two words", cap[31:16], 32'h3CA5);
        $display("sleep test done");
        // Nine-bit word with ninth bit set
        clr <= 1'b1;
        apb(1'b1, ssst_pkg::OFF_TX_CTRL, 32'h71);
        clr <= 1'b0;
        apb(1'b1, ssst_pkg::OFF_TX_HOLD, 32'h55);
        bits(9);
        run <= 1'b0;
        chk("nine bits", cap[31:23], 32'h155);
        apb(1'b1, ssst_pkg::OFF_ENABLES3, 32'h0);
        repeat (2) @(negedge pclk);
        chk("masked irq", irq, 1'b0);
        $display("nine bit and mask test done");
        // Transmit disabled: nothing leaves
        clr <= 1'b1;
        apb(1'b1, ssst_pkg::OFF_TX_CTRL, 32'h10);
        clr <= 1'b0;
        apb(1'b1, ssst_pkg::OFF_TX_HOLD, 32'hFF);
        run <= 1'b1;
        repeat (700) @(negedge pclk);
        run <= 1'b0;
        chk("no bits", ncap, 32'h0);
        $display("disable test done");
        end_sim();
    end
endmodule
bind ssst_top ssst_props i_ssst_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .data_out(data_out), .data_oe(data_oe));

/* File: core/ssst_pkg.sv */
// Package for the synchronous slave serial transmit block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package ssst_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_INT_CTRL  = 8'h00;  // interrupt_control
    localparam logic [7:0] OFF_FLAGS3    = 8'h04;  // peripheral_flags_three
    localparam logic [7:0] OFF_ENABLES3  = 8'h08;  // peripheral_enables_three
    localparam logic [7:0] OFF_PRIO3     = 8'h0C;  // peripheral_priority_three
    localparam logic [7:0] OFF_RX_CTRL   = 8'h10;  // port_two_receive_control
    localparam logic [7:0] OFF_TX_HOLD   = 8'h14;  // port_two_transmit_holding
    localparam logic [7:0] OFF_TX_CTRL   = 8'h18;  // port_two_transmit_control
    localparam logic [7:0] OFF_RATE_DIV  = 8'h1C;  // port_two_rate_divider
    localparam logic [7:0] OFF_LATCH_G   = 8'h20;  // port_g_output_latch
    localparam logic [7:0] OFF_SLEEP     = 8'h24;  // sleep control
    // Field positions
    localparam int TXC_CLK_SRC   = 7;
    localparam int TXC_NINE      = 6;
    localparam int TXC_TX_EN     = 5;
    localparam int TXC_SYNC      = 4;
    localparam int TXC_SHIFT_MT  = 1;
    localparam int TXC_NINTH_D   = 0;
    localparam int RXC_PORT_EN   = 7;
    localparam int RXC_SINGLE_RX = 5;
    localparam int RXC_CONT_RX   = 4;
    localparam int INT_GLOBAL    = 7;
    localparam int INT_PERIPH    = 6;
    localparam int FLG_TX        = 4;
    // Reset values
    localparam logic [7:0] RST_TX_CTRL = 8'h82;  // Master clock source, shifter empty
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_FLAGS3  = 8'h10;  // Holding register empty at reset
    localparam logic [3:0] BITS_EIGHT  = 4'h8;
    localparam logic [3:0] BITS_NINE   = 4'h9;

    typedef enum logic [1:0] {SH_IDLE, SH_LOAD, SH_BITS} ssst_state_t;

    // Word queued in the holding register
    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       nine;
    } ssst_word_t;
endpackage

/* File: core/ssst_top.sv */
// Synchronous slave transmitter of the second serial port, with APB registers.
// Assumes the external master drives the shift clock pin; it is sampled on pclk.
// How it works
// - Clear clock source bit selects slave
// - Shift only on externally supplied clock
// - Keeps shifting while chip sleeps
// - First queued word loads shifter immediately
// - Second word waits, flag stays clear
// - After first word, load second, set flag
// - Flag with enable raises wake interrupt
// - Nine-bit select sends nine bits
// - Ninth bit taken from ninth-data bit
// - Transmit only while transmit enable set
// - Holding write starts transmission when free
`timescale 1ns/1ps
module ssst_top (
    input  wire logic        pclk,        // System clock, 250 MHz
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB enable
    input  wire logic        pwrite,      // APB direction
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error, unmapped address
    input  wire logic        clk_pin_in,  // Shift clock from external master
    output logic             clk_pin_out, // Shift clock drive, always low
    output logic             clk_pin_oe,  // Shift clock enable, never driven
    output logic             data_out,    // Serial data out
    output logic             data_oe,     // Data pin enable
    output logic             irq,         // Level interrupt, masked events
    output logic             wake         // Wake from sleep request
);
    logic [7:0] int_ctrl_r, flags3_r, enables3_r, prio3_r, rx_ctrl_r;
    logic [7:0] tx_ctrl_r, rate_div_r, latch_g_r;
    logic       sleep_r;
    ssst_pkg::ssst_word_t hold_r;
    logic       hold_full_r;
    logic [8:0] shift_r;
    logic [3:0] bits_left_r;
    ssst_pkg::ssst_state_t state_r;
    logic [2:0] ck_sync_r;
    logic       shift_empty;
    logic       access, wr, rd;
    logic       slave_mode, tx_active, ck_fall;
    logic       load_shift, flag_set;

    assign access = psel & penable;
    assign wr     = access & pwrite;
    assign rd     = access & ~pwrite;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= ssst_pkg::OFF_SLEEP);
    endfunction

    // Slave mode needs sync, port enable and a cleared source bit
    assign slave_mode = ~tx_ctrl_r[ssst_pkg::TXC_CLK_SRC]
                      & tx_ctrl_r[ssst_pkg::TXC_SYNC]
                      & rx_ctrl_r[ssst_pkg::RXC_PORT_EN];
    assign tx_active  = slave_mode & tx_ctrl_r[ssst_pkg::TXC_TX_EN];

    // Two-stage synchroniser, edge found on stages two and three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_sync_r <= 3'h0;
        end else begin
            ck_sync_r <= {ck_sync_r[1:0], clk_pin_in};
        end
    end
    // Data changes on falling shift clock edge for the master to sample on rising
    assign ck_fall = ck_sync_r[2] & ~ck_sync_r[1];

    // Holding register moves into an idle shifter; no pclk dependence on sleep
    assign shift_empty = (state_r == ssst_pkg::SH_IDLE);
    assign load_shift  = tx_active & hold_full_r & shift_empty;
    // Flag tracks holding-empty; asleep, the second load comes only after the first word
    assign flag_set    = load_shift;

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ctrl_r <= ssst_pkg::RST_ZERO;
            enables3_r <= ssst_pkg::RST_ZERO;
            prio3_r    <= ssst_pkg::RST_ZERO;
            rx_ctrl_r  <= ssst_pkg::RST_ZERO;
            tx_ctrl_r  <= ssst_pkg::RST_TX_CTRL;
            rate_div_r <= ssst_pkg::RST_ZERO;
            latch_g_r  <= ssst_pkg::RST_ZERO;
            sleep_r    <= 1'b0;
        end else begin
            if (wr) begin
                case (paddr)
                    ssst_pkg::OFF_INT_CTRL: int_ctrl_r <= pwdata[7:0];
                    ssst_pkg::OFF_ENABLES3: enables3_r <= pwdata[7:0];
                    ssst_pkg::OFF_PRIO3:    prio3_r    <= pwdata[7:0];
                    ssst_pkg::OFF_RX_CTRL:  rx_ctrl_r  <= pwdata[7:0];
                    ssst_pkg::OFF_TX_CTRL:  tx_ctrl_r  <= pwdata[7:0];
                    ssst_pkg::OFF_RATE_DIV: rate_div_r <= pwdata[7:0];
                    ssst_pkg::OFF_LATCH_G:  latch_g_r  <= pwdata[7:0];
                    ssst_pkg::OFF_SLEEP:    sleep_r    <= pwdata[0];
                    default: ;
                endcase
            end
            // Any unmasked wake interrupt ends sleep
            if (wake) begin
                sleep_r <= 1'b0;
            end
        end
    end

    // Holding register: written by software, emptied into the shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r      <= '0;
            hold_full_r <= 1'b0;
        end else begin
            if (wr && paddr == ssst_pkg::OFF_TX_HOLD) begin
                // Ninth bit latched with the word, so set it first
                hold_r.data  <= pwdata[7:0];
                hold_r.ninth <= tx_ctrl_r[ssst_pkg::TXC_NINTH_D];
                hold_r.nine  <= tx_ctrl_r[ssst_pkg::TXC_NINE];
                hold_full_r  <= 1'b1;
            end else if (load_shift) begin
                hold_full_r <= 1'b0;
            end
        end
    end

    // Shifter runs only on external clock edges, so it works during sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r     <= 9'h1FF;
            bits_left_r <= 4'h0;
            state_r     <= ssst_pkg::SH_IDLE;
            data_out    <= 1'b1;
            data_oe     <= 1'b0;
        end else begin
            data_oe <= tx_active;
            // Released line returns to its idle level
            if (!tx_active) begin
                data_out <= 1'b1;
            end
            case (state_r)
                ssst_pkg::SH_IDLE: begin
                    if (load_shift) begin
                        shift_r     <= {hold_r.ninth, hold_r.data};
                        bits_left_r <= hold_r.nine ? ssst_pkg::BITS_NINE
                                                   : ssst_pkg::BITS_EIGHT;
                        state_r     <= ssst_pkg::SH_BITS;
                    end
                end
                ssst_pkg::SH_BITS: begin
                    if (!tx_active) begin
                        state_r <= ssst_pkg::SH_IDLE;
                    end else if (ck_fall) begin
                        // Idle right after the last bit, so the next word is ready
                        // before the next falling edge and no clock is wasted
                        data_out    <= shift_r[0];
                        shift_r     <= {1'b1, shift_r[8:1]};
                        bits_left_r <= bits_left_r - 4'h1;
                        if (bits_left_r == 4'h1) begin
                            state_r <= ssst_pkg::SH_IDLE;
                        end
                    end
                end
                default: state_r <= ssst_pkg::SH_IDLE;
            endcase
        end
    end

    // Transmit flag is a level: set while holding empty, after a load (set beats a flag write, a holding write beats set)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags3_r <= ssst_pkg::RST_FLAGS3;
        end else begin
            if (wr && paddr == ssst_pkg::OFF_FLAGS3) begin
                flags3_r <= flags3_r & ~pwdata[7:0];
            end
            if (wr && paddr == ssst_pkg::OFF_TX_HOLD) begin
                flags3_r[ssst_pkg::FLG_TX] <= 1'b0;
            end else if (flag_set) begin
                flags3_r[ssst_pkg::FLG_TX] <= 1'b1;
            end
        end
    end

    // Interrupt and wake outputs, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= |(flags3_r & enables3_r)
                  & int_ctrl_r[ssst_pkg::INT_GLOBAL]
                  & int_ctrl_r[ssst_pkg::INT_PERIPH];
            wake <= sleep_r & |(flags3_r & enables3_r);
        end
    end

    // APB answers in the access cycle; reads registered from setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    ssst_pkg::OFF_INT_CTRL: prdata[7:0] <= int_ctrl_r;
                    ssst_pkg::OFF_FLAGS3:   prdata[7:0] <= flags3_r;
                    ssst_pkg::OFF_ENABLES3: prdata[7:0] <= enables3_r;
                    ssst_pkg::OFF_PRIO3:    prdata[7:0] <= prio3_r;
                    ssst_pkg::OFF_RX_CTRL:  prdata[7:0] <= rx_ctrl_r;
                    ssst_pkg::OFF_TX_CTRL:  prdata[7:0] <= {tx_ctrl_r[7:2],
                                                           shift_empty,
                                                           tx_ctrl_r[0]};
                    ssst_pkg::OFF_RATE_DIV: prdata[7:0] <= rate_div_r;
                    ssst_pkg::OFF_LATCH_G:  prdata[7:0] <= latch_g_r;
                    ssst_pkg::OFF_SLEEP:    prdata[0]   <= sleep_r;
                    default: ;
                endcase
            end
        end
    end

    // Shift clock pin is input only in every mode, master source included
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_pin_out <= 1'b0;
            clk_pin_oe  <= 1'b0;
        end else begin
            clk_pin_out <= 1'b0;
            clk_pin_oe  <= 1'b0;
        end
    end
endmodule
